// ===== shared/pdr_pkg.sv
// pin driver package: register map, pin capability masks, carrier types
package pdr_pkg;
	localparam int NPIN = 32;
	localparam int PORT_W = 8;

	localparam logic [7:0] OFS_DRV_A = 8'h08;
	localparam logic [7:0] OFS_DRV_B = 8'h09;
	localparam logic [7:0] OFS_OE_A = 8'h0c;
	localparam logic [7:0] OFS_OE_B = 8'h0d;
	localparam logic [7:0] OFS_DRV_C = 8'h16;
	localparam logic [7:0] OFS_DRV_D = 8'h17;
	localparam logic [7:0] OFS_OE_C = 8'h1a;
	localparam logic [7:0] OFS_OE_D = 8'h1b;

	localparam logic [7:0] DRV_RST = 8'h00;
	localparam logic [7:0] DRV_AB_MASK = 8'hff;
	localparam logic [7:0] DRV_C_MASK = 8'h9c;
	localparam logic [7:0] DRV_D_MASK = 8'h06;
	localparam logic [7:0] RD_UNMAPPED = 8'h00;

	// flat pin index = port * 8 + pin, ports a b c d from bit 0 upward
	localparam logic [31:0] PIN_PRESENT = 32'h069cffff;
	localparam logic [31:0] PIN_OD_CAP = 32'h009cf0f0;
	localparam logic [31:0] PIN_SLEW_CAP = 32'h06000f0f;
	localparam logic [31:0] SMALL_ABSENT = 32'h040000ff;
	localparam int PIN_PC3 = 19;
	localparam int PIN_PC4 = 20;

	localparam logic [1:0] STRAP_SETTLE = 2'h3;

	typedef enum logic [2:0] {
		PM_MCU_IO,
		PM_LOGIC_OUT,
		PM_LOGIC_IN,
		PM_ADDR_OUT,
		PM_PERIPH_IO
	} pdr_mode_t;

	// allowed modes per port, bit n = mode with value n
	localparam logic [4:0] ALLOW_A = 5'h1f;
	localparam logic [4:0] ALLOW_B = 5'h0f;
	localparam logic [4:0] ALLOW_C = 5'h07;
	localparam logic [4:0] ALLOW_D = 5'h07;
	localparam logic [3:0][4:0] PORT_ALLOW = {ALLOW_D, ALLOW_C, ALLOW_B,
		ALLOW_A};

	typedef struct packed {
		logic mcu_dout;
		logic mcu_dir;
		logic pt_dout;
		logic pt_oe;
		logic addr_bit;
	} pdr_src_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} pdr_cfg_t;
endpackage

// ===== rtl/pdr_pin_cell.sv
// one pin driver: mode mux, drive type, enable view, input synchroniser
`timescale 1ns/10ps
module pdr_pin_cell
	import pdr_pkg::*;
#(
	parameter logic OD_CAP = 1'b0,
	parameter logic SLEW_CAP = 1'b0,
	parameter logic [4:0] ALLOW = 5'h01
)
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire pdr_mode_t mode,
	input wire pdr_src_t src,
	input wire logic periph_act,
	input wire logic periph_dir,
	input wire logic force_en,
	input wire logic force_val,
	input wire logic drv_sel,
	input wire logic absent,
	input wire logic pad_in,
	output logic pad_out_ff,
	output logic pad_oe_n_ff,
	output logic slew_fast_ff,
	output logic oe_view_ff,
	output logic level_ff
);
	pdr_mode_t eff;
	logic dout;
	logic oe;
	logic od;
	logic [2:0] sync_ff;

	always_comb
	begin
		// unsupported mode on this port falls back to processor i/o
		eff = ALLOW[mode] ? mode : PM_MCU_IO;
		dout = src.mcu_dout;
		oe = src.mcu_dir;
		unique case (eff)
			PM_MCU_IO:
			begin
				dout = src.mcu_dout;
				oe = src.mcu_dir;
			end
			PM_LOGIC_OUT:
			begin
				dout = src.pt_dout;
				oe = src.pt_oe;
			end
			PM_LOGIC_IN: oe = 1'b0;
			PM_ADDR_OUT:
			begin
				dout = src.addr_bit;
				oe = 1'b1;
			end
			PM_PERIPH_IO: oe = periph_act & periph_dir;
			default: oe = 1'b0;
		endcase
		if (force_en)
		begin
			dout = force_val;
			oe = 1'b1;
		end
		if (absent)
			oe = 1'b0;
		od = OD_CAP & drv_sel;
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pad_out_ff <= 1'b0;
			pad_oe_n_ff <= 1'b1;
			slew_fast_ff <= 1'b0;
			oe_view_ff <= 1'b0;
		end
		else
		begin
			// open drain only pulls low, a high becomes release
			pad_out_ff <= od ? 1'b0 : dout;
			pad_oe_n_ff <= !(oe && !(od && dout));
			slew_fast_ff <= SLEW_CAP & drv_sel;
			oe_view_ff <= oe;
		end
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sync_ff <= 3'h0;
			level_ff <= 1'b0;
		end
		else
		begin
			sync_ff <= {sync_ff[1:0], pad_in};
			if (sync_ff[1] == sync_ff[2])
				level_ff <= sync_ff[2];
		end
	end
endmodule

// ===== rtl/pdr_port_drive.sv
// port drive-type select registers and output-enable readback, ports a-d
// How it works
// - a set select bit gives the alternative drive; clear gives push-pull
// - all drive-select registers are zero after reset
// - port c select bits 7,4,3,2 give open drain; others inert
// - port d select bits 2 and 1 give fast slew; others unused
// - enable-out bit reads one while enabled, zero while disabled; an open-drain pin released for a high reads one
// - port c enable-out shows pins 7,4,3,2; test-port bits carry nothing
// - port d enable-out shows pin 2 in bit 2, pin 1 in bit 1
// - port a: pins 0-3 fast slew only, pins 4-7 open drain only
// - port b: pins 0-3 fast slew only, pins 4-7 open drain only
// - port a offers processor, logic out, logic in, address, repeater
// - port b offers processor, logic out, logic in, address modes
// - port c pins 2,3,4,7 offer processor, logic out, logic in
// - programming status and error pins 3,4 assigned together, exclusively
// - port c pin 3 may signal flash program or erase done
// - four test-port pins stay dedicated and never used otherwise
// - small package: port a and port d pin 2 have no pin
// - enable-out shows final combined enable, readable any time
`timescale 1ns/10ps
module pdr_port_drive
	import pdr_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire pdr_cfg_t cfg,
	input wire pdr_src_t [NPIN-1:0] pin_src,
	input wire pdr_mode_t [NPIN-1:0] pin_mode,
	input wire logic periph_en,
	input wire logic psel_hit,
	input wire logic bus_rd_active,
	input wire logic isp_6pin_en,
	input wire logic isp_status_indicator,
	input wire logic isp_error_indicator,
	input wire logic ready_busy_en,
	input wire logic flash_ready,
	input wire logic small_pkg_strap,
	input wire logic [NPIN-1:0] pad_in,
	output wire logic [NPIN-1:0] pad_out,
	output wire logic [NPIN-1:0] pad_oe_n,
	output wire logic [NPIN-1:0] pad_slew_fast,
	output wire logic [NPIN-1:0] pin_level,
	output logic [7:0] cfg_rdata_ff,
	output logic cfg_rvalid_ff
);
	logic [7:0] drv_a_ff;
	logic [7:0] drv_b_ff;
	logic [7:0] drv_c_ff;
	logic [7:0] drv_d_ff;
	logic [NPIN-1:0] drv_all;
	logic [NPIN-1:0] oe_view;
	logic [NPIN-1:0] force_en;
	logic [NPIN-1:0] force_val;
	logic [NPIN-1:0] absent;
	logic periph_act;
	logic [2:0] strap_sync_ff;
	logic [1:0] strap_cnt_ff;
	logic strap_done_ff;
	logic small_pkg_ff;

	assign drv_all = {drv_d_ff, drv_c_ff, drv_b_ff, drv_a_ff};
	assign periph_act = periph_en & psel_hit;
	assign absent = small_pkg_ff ? SMALL_ABSENT : '0;

	// package strap is taken once, after it settles past the release
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			strap_sync_ff <= 3'h0;
			strap_cnt_ff <= 2'h0;
			strap_done_ff <= 1'b0;
			small_pkg_ff <= 1'b0;
		end
		else
		begin
			strap_sync_ff <= {strap_sync_ff[1:0], small_pkg_strap};
			if (!strap_done_ff)
			begin
				if (strap_cnt_ff != STRAP_SETTLE)
					strap_cnt_ff <= strap_cnt_ff + 2'h1;
				else if (strap_sync_ff[1] == strap_sync_ff[2])
				begin
					small_pkg_ff <= strap_sync_ff[2];
					strap_done_ff <= 1'b1;
				end
			end
		end
	end

	// drive-select registers; only capable bits are stored
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			drv_a_ff <= DRV_RST;
			drv_b_ff <= DRV_RST;
			drv_c_ff <= DRV_RST;
			drv_d_ff <= DRV_RST;
		end
		else if (cfg.wr)
		begin
			unique case (cfg.addr)
				OFS_DRV_A: drv_a_ff <= cfg.wdata & DRV_AB_MASK;
				OFS_DRV_B: drv_b_ff <= cfg.wdata & DRV_AB_MASK;
				OFS_DRV_C: drv_c_ff <= cfg.wdata & DRV_C_MASK;
				OFS_DRV_D: drv_d_ff <= cfg.wdata & DRV_D_MASK;
				// enable-out offsets and the rest take no write
				default: drv_a_ff <= drv_a_ff;
			endcase
		end
	end

	// status and error take both pins at once and win over ready/busy
	always_comb
	begin
		force_en = '0;
		force_val = '0;
		if (isp_6pin_en)
		begin
			force_en[PIN_PC3] = 1'b1;
			force_val[PIN_PC3] = isp_status_indicator;
			force_en[PIN_PC4] = 1'b1;
			force_val[PIN_PC4] = isp_error_indicator;
		end
		else if (ready_busy_en)
		begin
			force_en[PIN_PC3] = 1'b1;
			force_val[PIN_PC3] = flash_ready;
		end
	end

	// test-port pins have no cell, so this block never drives them
	genvar gi;
	generate
		for (gi = 0; gi < NPIN; gi++)
		begin : g_pin
			if (PIN_PRESENT[gi])
			begin : g_cell
				pdr_pin_cell #(
					.OD_CAP(PIN_OD_CAP[gi]),
					.SLEW_CAP(PIN_SLEW_CAP[gi]),
					.ALLOW(PORT_ALLOW[gi / PORT_W])
				) u_cell (
					.mclk(mclk),
					.rst_n(rst_n),
					.mode(pin_mode[gi]),
					.src(pin_src[gi]),
					.periph_act(gi < PORT_W ? periph_act : 1'b0),
					.periph_dir(bus_rd_active),
					.force_en(force_en[gi]),
					.force_val(force_val[gi]),
					.drv_sel(drv_all[gi]),
					.absent(absent[gi]),
					.pad_in(pad_in[gi]),
					.pad_out_ff(pad_out[gi]),
					.pad_oe_n_ff(pad_oe_n[gi]),
					.slew_fast_ff(pad_slew_fast[gi]),
					.oe_view_ff(oe_view[gi]),
					.level_ff(pin_level[gi])
				);
			end
			else
			begin : g_none
				logic idle_ff;
				logic release_ff;
				always_ff @(posedge mclk or negedge rst_n)
				begin
					if (!rst_n)
					begin
						idle_ff <= 1'b0;
						release_ff <= 1'b1;
					end
					else
					begin
						idle_ff <= 1'b0;
						release_ff <= 1'b1;
					end
				end
				assign pad_out[gi] = idle_ff;
				assign pad_oe_n[gi] = release_ff;
				assign pad_slew_fast[gi] = idle_ff;
				assign oe_view[gi] = idle_ff;
				assign pin_level[gi] = idle_ff;
			end
		end
	endgenerate

	// read data one cycle after the strobe; unmapped reads zero
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cfg_rdata_ff <= RD_UNMAPPED;
			cfg_rvalid_ff <= 1'b0;
		end
		else
		begin
			cfg_rvalid_ff <= cfg.rd;
			if (cfg.rd)
			begin
				unique case (cfg.addr)
					OFS_DRV_A: cfg_rdata_ff <= drv_a_ff;
					OFS_DRV_B: cfg_rdata_ff <= drv_b_ff;
					OFS_DRV_C: cfg_rdata_ff <= drv_c_ff;
					OFS_DRV_D: cfg_rdata_ff <= drv_d_ff;
					OFS_OE_A: cfg_rdata_ff <= oe_view[7:0];
					OFS_OE_B: cfg_rdata_ff <= oe_view[15:8];
					OFS_OE_C: cfg_rdata_ff <= oe_view[23:16];
					OFS_OE_D: cfg_rdata_ff <= oe_view[31:24];
					default: cfg_rdata_ff <= RD_UNMAPPED;
				endcase
			end
		end
	end

	property p_drv_reset;
		@(posedge mclk) disable iff (!rst_n)
		(!strap_done_ff && strap_cnt_ff == 2'h0) |-> (drv_all == '0);
	endproperty
	a_drv_reset: assert property (p_drv_reset)
		else $error("drive select not zero after reset");

	property p_c_write;
		@(posedge mclk) disable iff (!rst_n)
		(cfg.wr && cfg.addr == OFS_DRV_C)
			|=> (drv_c_ff == ($past(cfg.wdata) & DRV_C_MASK));
	endproperty
	a_c_write: assert property (p_c_write)
		else $error("port c select write wrong");

	property p_d_bits;
		@(posedge mclk) disable iff (!rst_n)
		(drv_d_ff & ~DRV_D_MASK) == 8'h00;
	endproperty
	a_d_bits: assert property (p_d_bits)
		else $error("unused port d select bit set");

	property p_oe_write_ignored;
		@(posedge mclk) disable iff (!rst_n)
		(cfg.wr && (cfg.addr == OFS_OE_A || cfg.addr == OFS_OE_B ||
			cfg.addr == OFS_OE_C || cfg.addr == OFS_OE_D))
			|=> $stable(drv_all);
	endproperty
	a_oe_write_ignored: assert property (p_oe_write_ignored)
		else $error("enable-out write changed state");

	property p_read_c_view;
		@(posedge mclk) disable iff (!rst_n)
		(cfg.rd && cfg.addr == OFS_OE_C) |=> (cfg_rvalid_ff &&
			cfg_rdata_ff == $past(oe_view[23:16]) &&
			(cfg_rdata_ff & ~DRV_C_MASK) == 8'h00);
	endproperty
	a_read_c_view: assert property (p_read_c_view)
		else $error("port c enable-out read wrong");

	property p_read_d_view;
		@(posedge mclk) disable iff (!rst_n)
		(cfg.rd && cfg.addr == OFS_OE_D) |=> (cfg_rvalid_ff &&
			cfg_rdata_ff == $past(oe_view[31:24]) &&
			(cfg_rdata_ff & ~DRV_D_MASK) == 8'h00);
	endproperty
	a_read_d_view: assert property (p_read_d_view)
		else $error("port d enable-out read wrong");

	property p_a_slew;
		@(posedge mclk) disable iff (!rst_n)
		pad_slew_fast[7:4] == 4'h0 ##0
			pad_slew_fast[3:0] == $past(drv_a_ff[3:0]);
	endproperty
	a_a_slew: assert property (p_a_slew)
		else $error("port a slew capability wrong");

	property p_b_slew;
		@(posedge mclk) disable iff (!rst_n)
		pad_slew_fast[15:12] == 4'h0 ##0
			pad_slew_fast[11:8] == $past(drv_b_ff[3:0]);
	endproperty
	a_b_slew: assert property (p_b_slew)
		else $error("port b slew capability wrong");

	property p_isp_pair;
		@(posedge mclk) disable iff (!rst_n)
		(isp_6pin_en && drv_c_ff[4:3] == 2'h0 && !small_pkg_ff)
			|=> (!pad_oe_n[PIN_PC3] && !pad_oe_n[PIN_PC4] &&
			pad_out[PIN_PC3] == $past(isp_status_indicator) &&
			pad_out[PIN_PC4] == $past(isp_error_indicator));
	endproperty
	a_isp_pair: assert property (p_isp_pair)
		else $error("status and error pins not driven together");

	property p_ready_pin;
		@(posedge mclk) disable iff (!rst_n)
		(ready_busy_en && !isp_6pin_en && !drv_c_ff[3])
			|=> (!pad_oe_n[PIN_PC3] &&
			pad_out[PIN_PC3] == $past(flash_ready));
	endproperty
	a_ready_pin: assert property (p_ready_pin)
		else $error("ready pin not driven");

	property p_jtag_free;
		@(posedge mclk) disable iff (!rst_n)
		(pad_oe_n[22:21] == 2'h3) && (pad_oe_n[17:16] == 2'h3);
	endproperty
	a_jtag_free: assert property (p_jtag_free)
		else $error("test-port pin driven");

	property p_small_pkg;
		@(posedge mclk) disable iff (!rst_n)
		small_pkg_ff ##1 small_pkg_ff |->
			(pad_oe_n[7:0] == 8'hff && pad_oe_n[26] &&
			oe_view[7:0] == 8'h00 && !oe_view[26]);
	endproperty
	a_small_pkg: assert property (p_small_pkg)
		else $error("absent pin driven on small package");

	property p_view_drive;
		@(posedge mclk) disable iff (!rst_n)
		(drv_all == '0 ##1 drv_all == '0) |->
			(oe_view & PIN_PRESENT) == (~pad_oe_n & PIN_PRESENT);
	endproperty
	a_view_drive: assert property (p_view_drive)
		else $error("enable-out differs from push-pull driver");

	property p_od_release;
		@(posedge mclk) disable iff (!rst_n)
		(~pad_oe_n & pad_out & $past(drv_all & PIN_OD_CAP)) == '0;
	endproperty
	a_od_release: assert property (p_od_release)
		else $error("open-drain pin driven high");

	property p_periph_view;
		@(posedge mclk) disable iff (!rst_n)
		(periph_en && psel_hit && bus_rd_active && !small_pkg_ff &&
			pin_mode[0] == PM_PERIPH_IO) |=> oe_view[0];
	endproperty
	a_periph_view: assert property (p_periph_view)
		else $error("repeater enable missing from view");

	property p_read_a_view;
		@(posedge mclk) disable iff (!rst_n)
		(cfg.rd && cfg.addr == OFS_OE_A) |=> (cfg_rvalid_ff &&
			cfg_rdata_ff == $past(oe_view[7:0]));
	endproperty
	a_read_a_view: assert property (p_read_a_view)
		else $error("port a enable-out read wrong");
endmodule

// ===== dv/pdr_cpu_model.sv
// processor-side model: one-cycle register strobes on the config port
`timescale 1ns/10ps
module pdr_cpu_model
	import pdr_pkg::*;
(
	input wire logic mclk,
	output pdr_cfg_t cfg
);
	initial
	begin
		cfg = '0;
	end

	// released lines show inverted values so stale data never looks valid
	task automatic access(input logic w, input logic [7:0] a,
		input logic [7:0] d);
		@(posedge mclk);
		#1;
		cfg.wr = w;
		cfg.rd = ~w;
		cfg.addr = a;
		cfg.wdata = d;
		@(posedge mclk);
		#1;
		cfg.wr = 1'b0;
		cfg.rd = 1'b0;
		cfg.addr = ~a;
		cfg.wdata = ~d;
	endtask
endmodule

// ===== dv/pdr_port_drive_tb.sv
// self-checking bench for the port drive-select and enable-out block
`timescale 1ns/10ps
`define CHK(nm, e, g) \
	begin \
		n_tests++; \
		if ((g) !== (e)) \
		begin \
			n_errors++; \
			$display("unexpected %s exp %h got %h", nm, e, g); \
		end \
	end
module pdr_port_drive_tb
	import pdr_pkg::*;
;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	pdr_cfg_t cfg;
	pdr_src_t [NPIN-1:0] pin_src;
	pdr_mode_t [NPIN-1:0] pin_mode;
	logic isp_6pin_en, isp_stat, isp_err, rdy_en, flash_ready;
	logic periph_en, psel_hit, bus_rd, small_pkg;
	logic [NPIN-1:0] pad_in, pad_out, pad_oe_n, pad_slew_fast, pin_level;
	logic [7:0] cfg_rdata;
	logic cfg_rvalid;
	int n_errors = 0;
	int n_tests = 0;
	int cyc = 0;
	logic [31:0] seed = 32'h000144b3;
	logic [31:0] r;
	logic [15:0] q[$];
	logic [15:0] note;

	always #4 mclk = ~mclk;

	pdr_cpu_model i_cpu (.mclk(mclk), .cfg(cfg));

	pdr_port_drive i_dut (
		.mclk(mclk), .rst_n(rst_n), .cfg(cfg), .pin_src(pin_src),
		.pin_mode(pin_mode), .periph_en(periph_en), .psel_hit(psel_hit),
		.bus_rd_active(bus_rd), .isp_6pin_en(isp_6pin_en),
		.isp_status_indicator(isp_stat), .isp_error_indicator(isp_err),
		.ready_busy_en(rdy_en), .flash_ready(flash_ready),
		.small_pkg_strap(small_pkg), .pad_in(pad_in), .pad_out(pad_out),
		.pad_oe_n(pad_oe_n), .pad_slew_fast(pad_slew_fast),
		.pin_level(pin_level), .cfg_rdata_ff(cfg_rdata),
		.cfg_rvalid_ff(cfg_rvalid)
	);

	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		i_cpu.access(1'b1, a, d);
	endtask

	// expectation noted before the strobe, checked when rvalid shows
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		q.push_back({a, e});
		i_cpu.access(1'b0, a, 8'h00);
	endtask

	task automatic src(input logic [31:0] dir, input logic [31:0] dout);
		foreach (pin_src[i])
		begin
			pin_src[i].mcu_dir = dir[i];
			pin_src[i].mcu_dout = dout[i];
		end
	endtask

	task automatic views(input logic [31:0] e);
		rd(OFS_OE_A, e[7:0]);
		rd(OFS_OE_B, e[15:8]);
		rd(OFS_OE_C, e[23:16]);
		rd(OFS_OE_D, e[31:24]);
	endtask

	task automatic set_mode(input pdr_mode_t m);
		foreach (pin_mode[i])
			pin_mode[i] = m;
		tick(2);
	endtask

	task automatic wrap_up;
		$display("errors %0d tests %0d", n_errors, n_tests);
		if (n_errors == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	always @(negedge mclk)
	begin
		if (cfg_rvalid === 1'b1)
		begin
			note = (q.size() > 0) ? q.pop_front() : 16'hxxxx;
			`CHK("read data", note[7:0], cfg_rdata)
		end
	end

	always @(posedge mclk)
	begin
		cyc++;
		if (cyc > 3000)
		begin
			n_errors++;
			wrap_up();
		end
	end

	initial
	begin
		pin_src = '0;
		foreach (pin_mode[i])
			pin_mode[i] = PM_MCU_IO;
		{isp_6pin_en, isp_stat, isp_err, rdy_en, flash_ready} = '0;
		{periph_en, psel_hit, bus_rd, small_pkg} = '0;
		pad_in = '0;
		tick(3);
		rst_n = 1'b1;
		rd(OFS_DRV_A, DRV_RST);
		rd(OFS_DRV_B, DRV_RST);
		rd(OFS_DRV_C, DRV_RST);
		rd(OFS_DRV_D, DRV_RST);
		rd(8'h20, RD_UNMAPPED);
		wr(OFS_DRV_C, 8'hff);
		rd(OFS_DRV_C, DRV_C_MASK);
		wr(OFS_DRV_D, 8'hff);
		rd(OFS_DRV_D, DRV_D_MASK);
		wr(OFS_OE_C, 8'hff);
		rd(OFS_OE_C, 8'h00);
		rd(OFS_DRV_C, DRV_C_MASK);
		wr(OFS_DRV_C, 8'h00);
		wr(OFS_DRV_D, 8'h00);
		repeat (8)
		begin
			r = xs();
			src(r, ~r);
			tick(1);
			views(r & PIN_PRESENT);
		end
		src('0, '0);
		pad_in = xs();
		tick(6);
		`CHK("pin level", pad_in & PIN_PRESENT, pin_level)
		src('1, '1);
		wr(OFS_DRV_A, 8'hff);
		wr(OFS_DRV_C, 8'hff);
		wr(OFS_DRV_D, 8'hff);
		tick(2);
		`CHK("oe_n a", 8'hf0, pad_oe_n[7:0])
		`CHK("slew a", 8'h0f, pad_slew_fast[7:0])
		`CHK("oe_n c", 8'hff, pad_oe_n[23:16])
		`CHK("slew d", 8'h06, pad_slew_fast[31:24])
		rd(OFS_OE_C, 8'h9c);
		src('1, '0);
		tick(2);
		`CHK("oe_n c low", 8'h63, pad_oe_n[23:16])
		src('1, '1);
		wr(OFS_DRV_B, 8'h0f);
		wr(OFS_DRV_C, 8'h00);
		tick(2);
		`CHK("oe_n b", 8'h00, pad_oe_n[15:8])
		`CHK("slew b", 8'h0f, pad_slew_fast[15:8])
		`CHK("out c", 8'h9c, pad_out[23:16])
		`CHK("oe_n c pp", 8'h63, pad_oe_n[23:16])
		src('1, '0);
		isp_6pin_en = 1'b1;
		{isp_stat, isp_err} = 2'b11;
		tick(2);
		`CHK("isp pins", 2'b11, pad_out[PIN_PC4:PIN_PC3])
		isp_6pin_en = 1'b0;
		src('1, '1);
		rdy_en = 1'b1;
		flash_ready = 1'b0;
		tick(2);
		`CHK("ready pin", 2'b10, pad_out[PIN_PC4:PIN_PC3])
		rdy_en = 1'b0;
		wr(OFS_DRV_A, 8'h00);
		wr(OFS_DRV_B, 8'h00);
		pin_src = {NPIN{5'b00111}};
		{periph_en, psel_hit, bus_rd} = 3'b111;
		set_mode(PM_LOGIC_OUT);
		`CHK("logic out", PIN_PRESENT, pad_out)
		views(PIN_PRESENT);
		set_mode(PM_PERIPH_IO);
		views(32'h000000ff);
		bus_rd = 1'b0;
		views(32'h00000000);
		set_mode(PM_ADDR_OUT);
		views(32'h0000ffff);
		pin_src = {NPIN{5'b01111}};
		set_mode(PM_LOGIC_IN);
		views(32'h00000000);
		set_mode(PM_MCU_IO);
		src('1, '1);
		small_pkg = 1'b1;
		rst_n = 1'b0;
		tick(2);
		rst_n = 1'b1;
		tick(8);
		`CHK("oe_n small", 9'h1ff, {pad_oe_n[26], pad_oe_n[7:0]})
		rd(OFS_DRV_D, DRV_RST);
		views(PIN_PRESENT & ~SMALL_ABSENT);
		tick(4);
		`CHK("pending reads", 0, q.size())
		wrap_up();
	end
endmodule
